//--- verilog/regstore_xop_params.svh
/*
  constants for the register-store / trap executor: opcodes, fields,
  status bit positions, workspace offsets and vector table layout.
  assumes big-endian bit 0 = msb numbering maps to [15-n].
*/
`ifndef REGSTORE_XOP_PARAMS_SVH
`define REGSTORE_XOP_PARAMS_SVH
`define OPC_HI 15
`define OPC_LO 5
`define OPC_STORE_STATUS_INSTR 11'h016
`define OPC_STORE_WSP_INSTR 11'h015
`define OPC_AI 11'h011
`define OPC_CI 11'h014
`define OPC_LOAD_WSP_IMMEDIATE_INSTR 11'h017
`define OPC_RETURN_WITH_WORKSPACE_INSTR 11'h01c
`define XOP_HI 15
`define XOP_LO 10
`define XOP_CODE 6'h0b
`define TRAP_HI 9
`define TRAP_LO 6
`define MODE_HI 5
`define MODE_LO 4
`define REG_HI 3
`define REG_LO 0
`define MODE_REG 2'h0
`define MODE_IND 2'h1
`define MODE_SYM 2'h2
`define ST_LGT 15
`define ST_AGT 14
`define ST_EQ 13
`define ST_C 12
`define ST_OV 11
`define ST_TRAP 9
`define XOP_VEC_BASE 16'h0040
`define XOP_PC_OFS 16'h0002
`define WORD_STEP 16'h0002
`define WREG_R11 4'hb
`define WREG_R13 4'hd
`define WREG_R14 4'he
`define WREG_R15 4'hf
`endif

//--- verilog/regstore_xop_pkg.sv
/*
  types for the register-store / trap executor.
  assumes nothing beyond the params header.
*/
package regstore_xop_pkg;
  typedef enum logic [2:0] {
    OP_STORE_STATUS_INSTR, OP_STORE_WSP_INSTR, OP_AI, OP_CI, OP_LOAD_WSP_IMMEDIATE_INSTR, OP_XOP, OP_RETURN_WITH_WORKSPACE_INSTR, OP_BAD
  } op_t;
  typedef enum logic [4:0] {
    S_IDLE, S_IMM, S_RREG, S_WREG, S_XREG, S_XSYM, S_XIDX, S_XINC,
    S_VWP, S_VPC, S_W11, S_W13, S_W14, S_W15, S_R13, S_R14, S_R15, S_DONE
  } state_t;
endpackage : regstore_xop_pkg

//--- verilog/regstore_xop_exec.sv
/*
  executes store-status, store-wsp, add/compare immediate, load-wsp
  immediate, extended-op trap and return-with-workspace.
  assumes a word memory on the same clock: memReq held until a one-cycle
  memAck; read data valid with memAck. pcOut points past the opcode
  word when instrValid is given.
*/
`timescale 1ns/100ps
`default_nettype none
`include "regstore_xop_params.svh"

// Summary of operation
// [RULE1] store-status and store-wsp copy status or wsp to register, status kept
// [RULE2] store-wsp writes the address of workspace register 0
// [RULE3] add-immediate adds the second word to the register, writes the sum
// [RULE4] compare-immediate sets equal bit on match, register untouched
// [RULE5] load-wsp-immediate loads the second word into the workspace pointer
// [RULE6] trap source mode and register decode as a general source operand
// [RULE7] trap sets status bit 6
// [RULE8] trap vector at 0x40 plus four times number, pc in next word
// [RULE9] sixteen trap numbers, each with wsp and pc vector words
// [RULE10] trap saves old wsp, pc, status in new registers 13, 14, 15
// [RULE11] trap writes source effective address into new register 11
// [RULE12] no interrupt request sampling after a trap completes
// [RULE13] return restores wsp, pc, status from registers 13, 14, 15
// [RULE14] store instructions take register from bits 12-15, ignore bit 11
// [RULE15] workspace register n lives at wsp plus two times n
module regstore_xop_exec (
  input wire logic clock,
  input wire logic rst,
  input wire logic instrValid,
  input wire logic [15:0] instrWord,
  output logic instrReady,
  output logic memReq,
  output logic memWe,
  output logic [15:0] memAddr,
  output logic [15:0] memWdata,
  input wire logic [15:0] memRdata,
  input wire logic memAck,
  input wire logic intReqN,
  output logic [15:0] pcOut,
  output logic [15:0] wpOut,
  output logic [15:0] stOut,
  output logic done,
  output logic illegal,
  output logic intPending
);
  import regstore_xop_pkg::*;

  regstore_xop_pkg::state_t state_reg, state_next;
  regstore_xop_pkg::op_t op_reg, op_next;
  logic [15:0] instr_reg, instr_next;
  logic [15:0] pc_reg, pc_next, wp_reg, wp_next, st_reg, st_next;
  logic [15:0] imm_reg, imm_next, opnd_reg, opnd_next;
  logic [15:0] src_reg, src_next, newWp_reg, newWp_next;
  logic illegal_reg, illegal_next, intPend_reg, intPend_next;
  logic intSync1_reg, intSync2_reg;
  logic [3:0] regN, trapN;
  logic [1:0] mode;
  logic [16:0] sum;
  logic [15:0] vecAddr;
  op_t dec;

  function automatic logic [15:0] wsAddr(input logic [15:0] base,
                                         input logic [3:0] n);
    wsAddr = base + {11'h000, n, 1'b0}; // RULE15
  endfunction : wsAddr

  assign regN = instr_reg[`REG_HI:`REG_LO]; // RULE14
  assign trapN = instr_reg[`TRAP_HI:`TRAP_LO];
  assign mode = instr_reg[`MODE_HI:`MODE_LO]; // RULE6
  assign sum = {1'b0, opnd_reg} + {1'b0, imm_reg};
  assign vecAddr = `XOP_VEC_BASE + {10'h000, trapN, 2'h0}; // RULE8 RULE9

  always_comb begin
    case (instrWord[`OPC_HI:`OPC_LO])
      `OPC_STORE_STATUS_INSTR: dec = OP_STORE_STATUS_INSTR;
      `OPC_STORE_WSP_INSTR: dec = OP_STORE_WSP_INSTR;
      `OPC_AI: dec = OP_AI;
      `OPC_CI: dec = OP_CI;
      `OPC_LOAD_WSP_IMMEDIATE_INSTR: dec = OP_LOAD_WSP_IMMEDIATE_INSTR;
      `OPC_RETURN_WITH_WORKSPACE_INSTR: dec = OP_RETURN_WITH_WORKSPACE_INSTR;
      default: dec = OP_BAD;
    endcase
    if (instrWord[`XOP_HI:`XOP_LO] == `XOP_CODE) begin
      dec = OP_XOP;
    end
  end

  // memory port: address and data follow the registered state only
  always_comb begin
    memReq = 1'b1;
    memWe = 1'b0;
    memAddr = 16'h0000;
    memWdata = 16'h0000;
    case (state_reg)
      S_IMM, S_XSYM: memAddr = pc_reg;
      S_RREG, S_XREG, S_XIDX: memAddr = wsAddr(wp_reg, regN);
      S_WREG: begin
        memWe = 1'b1;
        memAddr = wsAddr(wp_reg, regN);
        if (op_reg == OP_STORE_STATUS_INSTR) begin
          memWdata = st_reg; // RULE1
        end else if (op_reg == OP_STORE_WSP_INSTR) begin
          memWdata = wp_reg; // RULE1 RULE2
        end else begin
          memWdata = sum[15:0]; // RULE3
        end
      end
      S_XINC: begin
        memWe = 1'b1;
        memAddr = wsAddr(wp_reg, regN);
        memWdata = src_reg + `WORD_STEP;
      end
      S_VWP: memAddr = vecAddr;
      S_VPC: memAddr = vecAddr + `XOP_PC_OFS;
      S_W11: begin
        memWe = 1'b1;
        memAddr = wsAddr(newWp_reg, `WREG_R11);
        memWdata = src_reg; // RULE11
      end
      S_W13: begin
        memWe = 1'b1;
        memAddr = wsAddr(newWp_reg, `WREG_R13);
        memWdata = wp_reg; // RULE10
      end
      S_W14: begin
        memWe = 1'b1;
        memAddr = wsAddr(newWp_reg, `WREG_R14);
        memWdata = pc_reg; // RULE10
      end
      S_W15: begin
        memWe = 1'b1;
        memAddr = wsAddr(newWp_reg, `WREG_R15);
        memWdata = st_reg; // RULE10
      end
      S_R13: memAddr = wsAddr(wp_reg, `WREG_R13); // RULE13
      S_R14: memAddr = wsAddr(wp_reg, `WREG_R14); // RULE13
      S_R15: memAddr = wsAddr(wp_reg, `WREG_R15); // RULE13
      default: memReq = 1'b0;
    endcase
  end

  always_comb begin
    state_next = state_reg;
    op_next = op_reg;
    instr_next = instr_reg;
    pc_next = pc_reg;
    wp_next = wp_reg;
    st_next = st_reg;
    imm_next = imm_reg;
    opnd_next = opnd_reg;
    src_next = src_reg;
    newWp_next = newWp_reg;
    illegal_next = 1'b0;
    intPend_next = intPend_reg;
    case (state_reg)
      S_IDLE: begin
        if (instrValid) begin
          op_next = dec;
          instr_next = instrWord;
          case (dec)
            OP_STORE_STATUS_INSTR, OP_STORE_WSP_INSTR: state_next = S_WREG;
            OP_AI, OP_CI, OP_LOAD_WSP_IMMEDIATE_INSTR: state_next = S_IMM;
            OP_RETURN_WITH_WORKSPACE_INSTR: state_next = S_R13;
            OP_XOP: begin
              if (instrWord[`MODE_HI:`MODE_LO] == `MODE_REG) begin
                src_next = wsAddr(wp_reg, instrWord[`REG_HI:`REG_LO]);
                state_next = S_VWP; // RULE6
              end else if (instrWord[`MODE_HI:`MODE_LO] == `MODE_SYM) begin
                state_next = S_XSYM; // RULE6
              end else begin
                state_next = S_XREG; // RULE6
              end
            end
            default: begin
              illegal_next = 1'b1;
              state_next = S_DONE;
            end
          endcase
        end
      end
      S_IMM: if (memAck) begin
        imm_next = memRdata;
        pc_next = pc_reg + `WORD_STEP;
        if (op_reg == OP_LOAD_WSP_IMMEDIATE_INSTR) begin
          wp_next = memRdata; // RULE5
          state_next = S_DONE;
        end else begin
          state_next = S_RREG;
        end
      end
      S_RREG: if (memAck) begin
        opnd_next = memRdata;
        if (op_reg == OP_CI) begin
          // compare only: the register is never written back
          st_next[`ST_LGT] = memRdata > imm_reg;
          st_next[`ST_AGT] = $signed(memRdata) > $signed(imm_reg);
          st_next[`ST_EQ] = memRdata == imm_reg; // RULE4
          state_next = S_DONE;
        end else begin
          state_next = S_WREG;
        end
      end
      S_WREG: if (memAck) begin
        if (op_reg == OP_AI) begin
          st_next[`ST_LGT] = sum[15:0] != 16'h0000;
          st_next[`ST_AGT] = !sum[15] && sum[15:0] != 16'h0000;
          st_next[`ST_EQ] = sum[15:0] == 16'h0000;
          st_next[`ST_C] = sum[16];
          st_next[`ST_OV] = (opnd_reg[15] == imm_reg[15]) &&
                            (sum[15] != opnd_reg[15]); // RULE3
        end
        state_next = S_DONE;
      end
      S_XREG: if (memAck) begin
        src_next = memRdata;
        state_next = mode[1] ? S_XINC : S_VWP;
      end
      S_XSYM: if (memAck) begin
        pc_next = pc_reg + `WORD_STEP;
        imm_next = memRdata;
        src_next = memRdata;
        state_next = (regN == 4'h0) ? S_VWP : S_XIDX;
      end
      S_XIDX: if (memAck) begin
        src_next = imm_reg + memRdata;
        state_next = S_VWP;
      end
      S_XINC: if (memAck) begin
        state_next = S_VWP;
      end
      S_VWP: if (memAck) begin
        newWp_next = memRdata; // RULE8
        state_next = S_VPC;
      end
      S_VPC: if (memAck) begin
        imm_next = memRdata; // RULE8
        state_next = S_W11;
      end
      S_W11: if (memAck) begin
        state_next = S_W13;
      end
      S_W13: if (memAck) begin
        state_next = S_W14;
      end
      S_W14: if (memAck) begin
        state_next = S_W15;
      end
      S_W15: if (memAck) begin
        wp_next = newWp_reg;
        pc_next = imm_reg;
        st_next[`ST_TRAP] = 1'b1; // RULE7
        state_next = S_DONE;
      end
      S_R13: if (memAck) begin
        newWp_next = memRdata;
        state_next = S_R14;
      end
      S_R14: if (memAck) begin
        imm_next = memRdata;
        state_next = S_R15;
      end
      S_R15: if (memAck) begin
        st_next = memRdata; // RULE13
        wp_next = newWp_reg;
        pc_next = imm_reg;
        state_next = S_DONE;
      end
      S_DONE: begin
        // the boundary after a trap skips the request so the handler
        // gets at least its first instruction
        if (op_reg != OP_XOP) begin
          intPend_next = !intSync2_reg; // RULE12
        end
        state_next = S_IDLE;
      end
      default: state_next = S_IDLE;
    endcase
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_reg <= S_IDLE;
      op_reg <= OP_BAD;
      instr_reg <= 16'h0000;
      pc_reg <= 16'h0000;
      wp_reg <= 16'h0000;
      st_reg <= 16'h0000;
      imm_reg <= 16'h0000;
      opnd_reg <= 16'h0000;
      src_reg <= 16'h0000;
      newWp_reg <= 16'h0000;
      illegal_reg <= 1'b0;
      intPend_reg <= 1'b0;
      intSync1_reg <= 1'b1;
      intSync2_reg <= 1'b1;
    end else begin
      state_reg <= state_next;
      op_reg <= op_next;
      instr_reg <= instr_next;
      pc_reg <= pc_next;
      wp_reg <= wp_next;
      st_reg <= st_next;
      imm_reg <= imm_next;
      opnd_reg <= opnd_next;
      src_reg <= src_next;
      newWp_reg <= newWp_next;
      illegal_reg <= illegal_next;
      intPend_reg <= intPend_next;
      intSync1_reg <= intReqN;
      intSync2_reg <= intSync1_reg;
    end
  end

  assign instrReady = state_reg == S_IDLE;
  assign done = state_reg == S_DONE;
  assign illegal = illegal_reg;
  assign intPending = intPend_reg;
  assign pcOut = pc_reg;
  assign wpOut = wp_reg;
  assign stOut = st_reg;

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  property p_store_keeps_st;
    state_reg == S_WREG && (op_reg == OP_STORE_STATUS_INSTR || op_reg == OP_STORE_WSP_INSTR)
      |=> st_reg == $past(st_reg);
  endproperty
  a_store_keeps_st: assert property (p_store_keeps_st) // RULE1
    else $error("store instruction changed status");

  property p_store_wsp_instr_data;
    state_reg == S_WREG && op_reg == OP_STORE_WSP_INSTR |-> memWdata == wp_reg && memWe;
  endproperty
  a_store_wsp_instr_data: assert property (p_store_wsp_instr_data) // RULE2
    else $error("store-wsp wrote wrong value");

  property p_ai_sum;
    state_reg == S_WREG && op_reg == OP_AI
      |-> memWdata == opnd_reg + imm_reg && memAddr == wp_reg + {regN, 1'b0};
  endproperty
  a_ai_sum: assert property (p_ai_sum) // RULE3
    else $error("add-immediate sum wrong");

  property p_ci_eq;
    state_reg == S_DONE && op_reg == OP_CI
      |-> st_reg[`ST_EQ] == (opnd_reg == imm_reg);
  endproperty
  a_ci_eq: assert property (p_ci_eq) // RULE4
    else $error("compare equal bit wrong");

  property p_load_wsp_immediate_instr;
    state_reg == S_DONE && op_reg == OP_LOAD_WSP_IMMEDIATE_INSTR |-> wp_reg == imm_reg;
  endproperty
  a_load_wsp_immediate_instr: assert property (p_load_wsp_immediate_instr) // RULE5
    else $error("load-wsp did not load");

  property p_xop_st6;
    state_reg == S_W15 && memAck |=> st_reg[`ST_TRAP] && done;
  endproperty
  a_xop_st6: assert property (p_xop_st6) // RULE7
    else $error("trap flag not set");

  property p_vec_addr;
    state_reg == S_VWP |-> memReq && !memWe &&
      memAddr == `XOP_VEC_BASE + {trapN, 2'h0};
  endproperty
  a_vec_addr: assert property (p_vec_addr) // RULE8
    else $error("trap vector address wrong");

  property p_r11;
    state_reg == S_W11 |-> memWe && memWdata == src_reg &&
      memAddr == newWp_reg + 16'h0016;
  endproperty
  a_r11: assert property (p_r11) // RULE11
    else $error("source address not written to r11");

  property p_no_int_after_xop;
    done && op_reg == OP_XOP |=> intPending == $past(intPending);
  endproperty
  a_no_int_after_xop: assert property (p_no_int_after_xop) // RULE12
    else $error("interrupt sampled after trap");

  property p_reg_addr;
    state_reg == S_RREG |-> memAddr == wp_reg + {11'h000, regN, 1'b0};
  endproperty
  a_reg_addr: assert property (p_reg_addr) // RULE15
    else $error("workspace register address wrong");

  property p_save_wp;
    state_reg == S_W13 |-> memWe && memWdata == wp_reg &&
      memAddr == newWp_reg + 16'h001a;
  endproperty
  a_save_wp: assert property (p_save_wp) // RULE10
    else $error("old workspace pointer not saved in r13");

  property p_return_with_workspace_instr_st;
    state_reg == S_R15 && memAck |=> st_reg == $past(memRdata) &&
      wp_reg == $past(newWp_reg);
  endproperty
  a_return_with_workspace_instr_st: assert property (p_return_with_workspace_instr_st) // RULE13
    else $error("return did not restore status and workspace");
endmodule : regstore_xop_exec
`default_nettype wire

//--- sim/word_mem_model.sv
/*
  word memory partner: byte addresses, one-cycle ack after 0..3 waits.
  assumes requester holds memReq and qualifiers until memAck.
*/
`timescale 1ns/100ps
`default_nettype none
module word_mem_model (
  input wire logic clock,
  input wire logic rst,
  input wire logic memReq,
  input wire logic memWe,
  input wire logic [15:0] memAddr,
  input wire logic [15:0] memWdata,
  input wire logic [1:0] ackDelay,
  output logic [15:0] memRdata,
  output logic memAck
);
  logic [15:0] m [0:32767];
  logic [1:0] waitCnt;
  logic [15:0] lastRd;
  // data off the ack cycle is garbage so stale reads show up
  assign memAck = memReq && (waitCnt == ackDelay);
  assign memRdata = memAck ? m[memAddr[15:1]] : ~lastRd;
  initial begin
    for (int i = 0; i < 32768; i++) m[i] = 16'h0000;
  end
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      waitCnt <= 2'h0;
      lastRd <= 16'h0000;
    end else if (memAck) begin
      waitCnt <= 2'h0;
      lastRd <= memRdata;
      if (memWe) m[memAddr[15:1]] <= memWdata;
    end else if (memReq) begin
      waitCnt <= waitCnt + 2'h1;
    end
  end
endmodule : word_mem_model
`default_nettype wire

//--- sim/tb_regstore_xop_exec.sv
/*
  testbench for the register-store / trap executor.
  assumes the word memory model and a 25 MHz clock.
*/
`timescale 1ns/100ps
`default_nettype none
module tb_regstore_xop_exec;
  logic clock = 0, rst = 1, instrValid = 0, intReqN = 1;
  logic [15:0] instrWord = 16'h0000;
  logic instrReady, memReq, memWe, memAck, done, illegal, intPending;
  logic [15:0] memAddr, memWdata, memRdata, pcOut, wpOut, stOut;
  logic [1:0] ackDelay = 2'h0;
  logic [15:0] pc, wp, oWp, oPc, oSt, nWp, nPc, rv, sa, imm;
  logic [1:0] md;
  logic [3:0] sr;
  logic ill;
  int seed = 25, errCount = 0, nChecks = 0;

  always #20 clock = ~clock;

  regstore_xop_exec DUT (.clock(clock), .rst(rst), .instrValid(instrValid),
    .instrWord(instrWord), .instrReady(instrReady), .memReq(memReq),
    .memWe(memWe), .memAddr(memAddr), .memWdata(memWdata),
    .memRdata(memRdata), .memAck(memAck), .intReqN(intReqN), .pcOut(pcOut),
    .wpOut(wpOut), .stOut(stOut), .done(done), .illegal(illegal),
    .intPending(intPending));
  word_mem_model memModel (.clock(clock), .rst(rst), .memReq(memReq),
    .memWe(memWe), .memAddr(memAddr), .memWdata(memWdata),
    .ackDelay(ackDelay), .memRdata(memRdata), .memAck(memAck));

  task conclude;
    $display("checks %0d mismatches %0d", nChecks, errCount);
    if (errCount == 0 && nChecks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : conclude

  task chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    nChecks++;
    if (seen !== exp) begin
      errCount++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  function automatic logic [15:0] rd(input logic [15:0] a);
    return memModel.m[a[15:1]];
  endfunction : rd

  task wr(input logic [15:0] a, input logic [15:0] v);
    memModel.m[a[15:1]] = v;
  endtask : wr

  // called at a falling edge with the block idle
  task run(input logic [15:0] op);
    int k;
    ackDelay = 2'($random(seed));
    instrWord = op;
    instrValid = 1;
    for (k = 0; k < 50 && instrReady !== 1'b1; k++) @(negedge clock);
    if (instrReady !== 1'b1) begin
      errCount++;
      conclude();
    end
    @(negedge clock);
    instrValid = 0;
    for (k = 0; k < 300 && done !== 1'b1; k++) @(negedge clock);
    if (done !== 1'b1) begin
      errCount++;
      conclude();
    end
    ill = illegal;
    @(negedge clock);
  endtask : run

  task runImm(input logic [15:0] op, input logic [15:0] v);
    wr(pc, v);
    pc = pc + 16'h2;
    run(op);
  endtask : runImm

  initial begin
    repeat (8) @(negedge clock);
    rst = 0;
    chk("pc", pcOut, 16'h0000);
    chk("ready", {15'h0, instrReady}, 16'h0001);
    pc = 16'h0000;
    runImm(16'h02e0, 16'hfc00);
    wp = 16'hfc00;
    chk("wp", wpOut, wp);
    chk("pc", pcOut, pc);
    wr(wp + 16'h4, 16'h000f);
    runImm(16'h0222, 16'h00ff);
    chk("ai r2", rd(wp + 16'h4), 16'h010e);
    for (int i = 0; i < 6; i++) begin
      sr = 4'($random(seed));
      rv = 16'($random(seed));
      imm = 16'($random(seed));
      wr(wp + {11'h0, sr, 1'b0}, rv);
      runImm(16'h0220 | sr, imm);
      chk("ai rn", rd(wp + {11'h0, sr, 1'b0}), rv + imm);
    end
    wr(wp + 16'h4, 16'h010e);
    runImm(16'h0282, 16'h010e);
    chk("ci eq", {15'h0, stOut[13]}, 16'h0001);
    chk("ci reg", rd(wp + 16'h4), 16'h010e);
    runImm(16'h0282, 16'h010f);
    chk("ci ne", {15'h0, stOut[13]}, 16'h0000);
    run(16'h02a2);
    chk("store_wsp_instr r2", rd(wp + 16'h4), wp);
    run(16'h02b3);
    chk("store_wsp_instr r3", rd(wp + 16'h6), wp);
    run(16'h0000);
    chk("illegal", {15'h0, ill}, 16'h0001);
    chk("ill wp", wpOut, wp);
    chk("ill pc", pcOut, pc);
    $display("store and immediate tests done");
    for (int d = 0; d < 16; d++) begin
      rv = 16'($random(seed));
      oWp = {2'b01, rv[13:6], 6'h00};
      oPc = {4'h1, rv[11:1], 1'b0};
      oSt = 16'($random(seed)) & 16'hfdff;
      wr(wp + 16'd26, oWp);
      wr(wp + 16'd28, oPc);
      wr(wp + 16'd30, oSt);
      intReqN = 1;
      run(16'h0380);
      chk("return_with_workspace_instr wp", wpOut, oWp);
      chk("return_with_workspace_instr pc", pcOut, oPc);
      chk("return_with_workspace_instr st", stOut, oSt);
      run(16'h02cc);
      chk("store_status_instr", rd(oWp + 16'd24), oSt);
      chk("store_status_instr st", stOut, oSt);
      intReqN = 0;
      pc = oPc;
      md = 2'(d + 2);
      sr = (md == 2'h2 && (d & 4) == 0) ? 4'h0 : 4'($random(seed)) | 4'h1;
      rv = {16'($random(seed))} & 16'hfffe;
      wr(oWp + {11'h0, sr, 1'b0}, rv);
      nWp = 16'h8000 + 16'(d * 64);
      nPc = 16'h2000 + 16'(d * 4);
      wr(16'h0040 + 16'(4 * d), nWp);
      wr(16'h0042 + 16'(4 * d), nPc);
      sa = (md == 2'h0) ? oWp + {11'h0, sr, 1'b0} : rv;
      if (md == 2'h2) begin
        imm = 16'hff00 - 16'(d * 2);
        // register 0 means absolute, any other register indexes
        sa = (sr == 4'h0) ? imm : imm + rv;
        runImm(16'h2c00 | 16'(d << 6) | 16'h0020 | {12'h000, sr}, imm);
      end else begin
        run(16'h2c00 | 16'(d << 6) | {10'h000, md, 4'h0} | {12'h000, sr});
      end
      chk("xop wp", wpOut, nWp);
      chk("xop pc", pcOut, nPc);
      chk("xop st6", {15'h0, stOut[9]}, 16'h0001);
      chk("xop r11", rd(nWp + 16'd22), sa);
      chk("xop r13", rd(nWp + 16'd26), oWp);
      chk("xop r14", rd(nWp + 16'd28), pc);
      chk("xop r15", rd(nWp + 16'd30), oSt);
      chk("xop int", {15'h0, intPending}, 16'h0000);
      if (md == 2'h3)
        chk("xop inc", rd(oWp + {11'h0, sr, 1'b0}), rv + 16'h2);
      wp = nWp;
      $display("trap %0d mode %0d done", d, md);
    end
    run(16'h02c1);
    chk("int seen", {15'h0, intPending}, 16'h0001);
    $display("interrupt test done");
    conclude();
  end
endmodule : tb_regstore_xop_exec
`default_nettype wire
